// ### include/basic_mode_control_pkg.sv
// Purpose: Constants and carrier types for the basic mode control register block
// Assumes: 32-bit APB data, register word at byte address zero
// Notes:   Status word offset and its field layout are local additions
package basic_mode_control_pkg;
    localparam logic [11:0] basic_mode_control_addr_ctrl = 12'h000;
    localparam logic [11:0] basic_mode_control_addr_stat = 12'h004;
    // Control bit positions
    localparam int basic_mode_control_bit_reset = 15;
    localparam int basic_mode_control_bit_loopback = 14;
    localparam int basic_mode_control_bit_speed = 13;
    localparam int basic_mode_control_bit_aneg = 12;
    localparam int basic_mode_control_bit_pdown = 11;
    localparam int basic_mode_control_bit_isolate = 10;
    localparam int basic_mode_control_bit_restart = 9;
    localparam int basic_mode_control_bit_duplex = 8;
    localparam int basic_mode_control_bit_coltest = 7;
    // Status word field positions
    localparam int basic_mode_control_st_link_ll = 0;
    localparam int basic_mode_control_st_fault_lh = 1;
    localparam int basic_mode_control_st_event_sc = 2;
    localparam int basic_mode_control_st_cnt_lsb = 8;
    localparam int basic_mode_control_st_fixed_lsb = 4;
    localparam logic [3:0] basic_mode_control_fixed_val = 4'h5;
    localparam logic [15:0] basic_mode_control_ctrl_wmask = 16'hff80;
    // Timing
    localparam int basic_mode_control_clk_ns = 100;
    localparam int basic_mode_control_lb_dead_us = 500;
    localparam int basic_mode_control_lb_dead_cyc = (basic_mode_control_lb_dead_us * 1000) / basic_mode_control_clk_ns;
    localparam int basic_mode_control_sw_reset_cyc = 16;
    localparam logic [31:0] basic_mode_control_pslverr_none = 32'h0000_0000;

    typedef struct packed {
        logic aneg;
        logic speed;
        logic duplex;
    } basic_mode_control_strap_t;

    typedef struct packed {
        logic loopback;
        logic speed_100;
        logic full_duplex;
        logic aneg_en;
        logic aneg_restart;
        logic power_down;
        logic isolate;
        logic col_test;
    } basic_mode_control_ctrl_t;

    typedef enum logic [2:0] {
        basic_mode_control_idle = 3'b001,
        basic_mode_control_reset = 3'b010,
        basic_mode_control_done = 3'b100
    } basic_mode_control_state_t;
endpackage

// ### src/basic_mode_control_latch_bit.sv
// Purpose: One status bit of a selectable latching kind
// Assumes: Read pulse marks a completed management read of the bit
// Notes:   Kind 0 self clearing, 1 latched low, 2 latched high
`timescale 1ns/10ps
module basic_mode_control_latch_bit #(
    parameter int kind = 0
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Event and read
    input wire logic event_in,
    input wire logic rd_pulse,
    // Value
    output logic value_ff
);
    logic nxt_value;
    logic idle_val;

    assign idle_val = (kind == 1);

    always_comb begin
        nxt_value = value_ff;
        if (kind == 0) begin
            nxt_value = event_in;
        end else if (kind == 1) begin
            if (!event_in) begin
                nxt_value = 1'b0;
            end else if (rd_pulse) begin
                nxt_value = 1'b1;
            end
        end else begin
            if (event_in) begin
                nxt_value = 1'b1;
            end else if (rd_pulse) begin
                nxt_value = 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            value_ff <= (kind == 1);
        end else begin
            value_ff <= nxt_value;
        end
    end

    chk_latch_holds: assert property (@(posedge pclk) disable iff (!presetn)
        (kind != 0 && value_ff != idle_val && !rd_pulse) |=> value_ff != idle_val)
        else $error("latched bit released without a read");
endmodule // basic_mode_control_latch_bit

// ### src/basic_mode_control_regs.sv
// Purpose: Basic mode control register with APB access and a status word
// Assumes: Straps stable around reset; status events synchronous to pclk
// Notes:   Zero wait state APB slave; unmapped reads give zero with pslverr
//
// Overview of operation
// - Writing one to bit 15 starts soft reset; bit reads one until done.
// - Soft reset reloads strap defaults into speed, duplex and auto-negotiation.
// - Bit 14 set loops MAC transmit data into the receive path.
// - After loopback enable, receive data invalid for up to 500 us.
// - Bit 13 picks 100 or 10 Mb/s when auto-negotiation off; strapped.
// - Bit 12 set runs auto-negotiation and ignores bits 13 and 8.
// - Auto-negotiation enable resets from its strap input.
// - Power down bit ORed with active-low pin; pin assertion sets bit.
// - Bit 8 picks full or half duplex when auto-negotiation off; strapped.
// - Self-clearing status bit follows its event without software.
// - Clear-on-read field returns its value then clears on that read.
// - Latched-low bit stays zero until read.
// - Latched-high bit stays one until read.
// - Read-only fixed field returns default and ignores writes.
`timescale 1ns/10ps
module basic_mode_control_regs #(
    parameter int dead_cycles = basic_mode_control_pkg::basic_mode_control_lb_dead_cyc,
    parameter int reset_cycles = basic_mode_control_pkg::basic_mode_control_sw_reset_cyc,
    parameter int cnt_width = 8
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Straps and pins
    input wire basic_mode_control_pkg::basic_mode_control_strap_t strap,
    input wire logic power_down_interrupt_pin_n,
    // MII loopback path
    input wire logic [3:0] mac_txd,
    input wire logic mac_tx_en,
    input wire logic [3:0] line_rxd,
    input wire logic line_rx_dv,
    output logic [3:0] mii_rxd,
    output logic mii_rx_dv,
    // Status events
    input wire logic link_ok,
    input wire logic fault_event,
    input wire logic busy_event,
    input wire logic error_pulse,
    // Control outputs
    output basic_mode_control_pkg::basic_mode_control_ctrl_t ctrl,
    output logic eff_speed_100,
    output logic eff_full_duplex,
    output logic core_reset,
    output logic rx_dead
);
    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    logic acc;
    logic wr_ctrl;
    logic rd_stat;
    logic [15:0] ctrl_word;
    logic [15:0] stat_word;
    logic link_ll;
    logic fault_lh;
    logic event_sc;
    assign acc = psel && penable;
    assign wr_ctrl = acc && pwrite && (paddr == basic_mode_control_pkg::basic_mode_control_addr_ctrl);
    // Clear on the edge that captures read data, so an event in the access cycle is kept
    assign rd_stat = psel && !penable && !pwrite && (paddr == basic_mode_control_pkg::basic_mode_control_addr_stat);

    // ------------------------------------------------------------
    // Control register and soft reset sequencer
    // ------------------------------------------------------------
    basic_mode_control_pkg::basic_mode_control_ctrl_t nxt_ctrl;
    basic_mode_control_pkg::basic_mode_control_ctrl_t ctrl_ff;
    basic_mode_control_pkg::basic_mode_control_state_t state_ff, nxt_state;
    logic [7:0] rst_cnt_ff, nxt_rst_cnt;
    logic pin_ff, nxt_pin;
    logic strap_load_ff, nxt_strap_load;

    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_state = state_ff;
        nxt_rst_cnt = rst_cnt_ff;
        nxt_strap_load = 1'b0;
        nxt_pin = !power_down_interrupt_pin_n;
        case (state_ff)
            basic_mode_control_pkg::basic_mode_control_idle: begin
                if (wr_ctrl && pwdata[basic_mode_control_pkg::basic_mode_control_bit_reset]) begin
                    nxt_state = basic_mode_control_pkg::basic_mode_control_reset;
                    nxt_rst_cnt = 8'(reset_cycles - 1);
                end else if (wr_ctrl) begin
                    nxt_ctrl.loopback = pwdata[basic_mode_control_pkg::basic_mode_control_bit_loopback];
                    nxt_ctrl.speed_100 = pwdata[basic_mode_control_pkg::basic_mode_control_bit_speed];
                    nxt_ctrl.aneg_en = pwdata[basic_mode_control_pkg::basic_mode_control_bit_aneg];
                    nxt_ctrl.power_down = pwdata[basic_mode_control_pkg::basic_mode_control_bit_pdown];
                    nxt_ctrl.isolate = pwdata[basic_mode_control_pkg::basic_mode_control_bit_isolate];
                    nxt_ctrl.aneg_restart = pwdata[basic_mode_control_pkg::basic_mode_control_bit_restart] && pwdata[basic_mode_control_pkg::basic_mode_control_bit_aneg];
                    nxt_ctrl.full_duplex = pwdata[basic_mode_control_pkg::basic_mode_control_bit_duplex];
                    nxt_ctrl.col_test = pwdata[basic_mode_control_pkg::basic_mode_control_bit_coltest];
                end else begin
                    nxt_ctrl.aneg_restart = 1'b0;
                end
            end
            basic_mode_control_pkg::basic_mode_control_reset: begin
                nxt_rst_cnt = rst_cnt_ff - 8'h01;
                if (rst_cnt_ff == 8'h00) begin
                    nxt_state = basic_mode_control_pkg::basic_mode_control_done;
                end
            end
            basic_mode_control_pkg::basic_mode_control_done: begin
                nxt_state = basic_mode_control_pkg::basic_mode_control_idle;
                nxt_strap_load = 1'b1;
                nxt_ctrl = '0;
                nxt_ctrl.aneg_en = strap.aneg;
                nxt_ctrl.speed_100 = strap.speed;
                nxt_ctrl.full_duplex = strap.duplex;
            end
            default: begin
                nxt_state = basic_mode_control_pkg::basic_mode_control_idle;
            end
        endcase
        if (pin_ff) begin
            nxt_ctrl.power_down = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= '0;
            state_ff <= basic_mode_control_pkg::basic_mode_control_done;
            rst_cnt_ff <= 8'h00;
            pin_ff <= 1'b0;
            strap_load_ff <= 1'b0;
        end else begin
            ctrl_ff <= nxt_ctrl;
            state_ff <= nxt_state;
            rst_cnt_ff <= nxt_rst_cnt;
            pin_ff <= nxt_pin;
            strap_load_ff <= nxt_strap_load;
        end
    end

    // ------------------------------------------------------------
    // Loopback dead time and data path
    // ------------------------------------------------------------
    logic [19:0] dead_cnt_ff, nxt_dead_cnt;
    logic [3:0] nxt_rxd;
    logic nxt_rx_dv;
    logic [cnt_width-1:0] err_cnt_ff, nxt_err_cnt;
    logic [31:0] nxt_prdata;
    logic nxt_pslverr;
    logic pready_ff;
    logic [31:0] prdata_ff;
    logic pslverr_ff;
    logic nxt_eff_speed, nxt_eff_dup, eff_speed_ff, eff_dup_ff;
    logic core_reset_ff, rx_dead_ff;

    always_comb begin
        nxt_dead_cnt = dead_cnt_ff;
        if (nxt_ctrl.loopback && !ctrl_ff.loopback) begin
            nxt_dead_cnt = 20'(dead_cycles);
        end else if (dead_cnt_ff != 20'h00000) begin
            nxt_dead_cnt = dead_cnt_ff - 20'h00001;
        end
        if (ctrl_ff.loopback) begin
            nxt_rxd = mac_txd;
            nxt_rx_dv = mac_tx_en && (dead_cnt_ff == 20'h00000);
        end else begin
            nxt_rxd = line_rxd;
            nxt_rx_dv = line_rx_dv;
        end
        // Forced speed and duplex only matter with auto-negotiation off
        if (ctrl_ff.aneg_en) begin
            nxt_eff_speed = eff_speed_ff;
            nxt_eff_dup = eff_dup_ff;
        end else begin
            nxt_eff_speed = ctrl_ff.speed_100;
            nxt_eff_dup = ctrl_ff.full_duplex;
        end
        // Error counter saturates and clears on read
        nxt_err_cnt = err_cnt_ff;
        if (rd_stat) begin
            nxt_err_cnt = {{(cnt_width-1){1'b0}}, error_pulse};
        end else if (error_pulse && err_cnt_ff != {cnt_width{1'b1}}) begin
            nxt_err_cnt = err_cnt_ff + 1'b1;
        end
        // Read data
        nxt_prdata = prdata_ff;
        nxt_pslverr = 1'b0;
        if (psel && !penable && !pwrite) begin
            if (paddr == basic_mode_control_pkg::basic_mode_control_addr_ctrl) begin
                nxt_prdata = {16'h0000, ctrl_word};
            end else if (paddr == basic_mode_control_pkg::basic_mode_control_addr_stat) begin
                nxt_prdata = {16'h0000, stat_word};
            end else begin
                nxt_prdata = basic_mode_control_pkg::basic_mode_control_pslverr_none;
                nxt_pslverr = 1'b1;
            end
        end else if (psel && !penable) begin
            nxt_pslverr = (paddr != basic_mode_control_pkg::basic_mode_control_addr_ctrl) && (paddr != basic_mode_control_pkg::basic_mode_control_addr_stat);
        end
    end

    always_comb begin
        ctrl_word = '0;
        ctrl_word[basic_mode_control_pkg::basic_mode_control_bit_reset] = (state_ff != basic_mode_control_pkg::basic_mode_control_idle);
        ctrl_word[basic_mode_control_pkg::basic_mode_control_bit_loopback] = ctrl_ff.loopback;
        ctrl_word[basic_mode_control_pkg::basic_mode_control_bit_speed] = ctrl_ff.speed_100;
        ctrl_word[basic_mode_control_pkg::basic_mode_control_bit_aneg] = ctrl_ff.aneg_en;
        ctrl_word[basic_mode_control_pkg::basic_mode_control_bit_pdown] = ctrl_ff.power_down;
        ctrl_word[basic_mode_control_pkg::basic_mode_control_bit_isolate] = ctrl_ff.isolate;
        ctrl_word[basic_mode_control_pkg::basic_mode_control_bit_restart] = ctrl_ff.aneg_restart;
        ctrl_word[basic_mode_control_pkg::basic_mode_control_bit_duplex] = ctrl_ff.full_duplex;
        ctrl_word[basic_mode_control_pkg::basic_mode_control_bit_coltest] = ctrl_ff.col_test;
        stat_word = '0;
        stat_word[basic_mode_control_pkg::basic_mode_control_st_link_ll] = link_ll;
        stat_word[basic_mode_control_pkg::basic_mode_control_st_fault_lh] = fault_lh;
        stat_word[basic_mode_control_pkg::basic_mode_control_st_event_sc] = event_sc;
        stat_word[basic_mode_control_pkg::basic_mode_control_st_fixed_lsb +: 4] = basic_mode_control_pkg::basic_mode_control_fixed_val;
        stat_word[basic_mode_control_pkg::basic_mode_control_st_cnt_lsb +: cnt_width] = err_cnt_ff;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dead_cnt_ff <= 20'h00000;
            mii_rxd <= 4'h0;
            mii_rx_dv <= 1'b0;
            err_cnt_ff <= '0;
            prdata_ff <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
            pready_ff <= 1'b0;
            eff_speed_ff <= 1'b0;
            eff_dup_ff <= 1'b0;
            rx_dead_ff <= 1'b0;
            core_reset_ff <= 1'b1;
        end else begin
            rx_dead_ff <= (nxt_dead_cnt != 20'h00000);
            core_reset_ff <= (nxt_state != basic_mode_control_pkg::basic_mode_control_idle) || nxt_strap_load;
            dead_cnt_ff <= nxt_dead_cnt;
            mii_rxd <= nxt_rxd;
            mii_rx_dv <= nxt_rx_dv;
            err_cnt_ff <= nxt_err_cnt;
            prdata_ff <= nxt_prdata;
            pslverr_ff <= nxt_pslverr;
            pready_ff <= psel && !penable;
            eff_speed_ff <= nxt_eff_speed;
            eff_dup_ff <= nxt_eff_dup;
        end
    end

    // ------------------------------------------------------------
    // Status bits
    // ------------------------------------------------------------
    basic_mode_control_latch_bit #(.kind(1)) u_link (.pclk(pclk), .presetn(presetn), .event_in(link_ok),
        .rd_pulse(rd_stat), .value_ff(link_ll));
    basic_mode_control_latch_bit #(.kind(2)) u_fault (.pclk(pclk), .presetn(presetn), .event_in(fault_event),
        .rd_pulse(rd_stat), .value_ff(fault_lh));
    basic_mode_control_latch_bit #(.kind(0)) u_busy (.pclk(pclk), .presetn(presetn), .event_in(busy_event),
        .rd_pulse(rd_stat), .value_ff(event_sc));

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign ctrl = ctrl_ff;
    assign eff_speed_100 = eff_speed_ff;
    assign eff_full_duplex = eff_dup_ff;
    assign core_reset = core_reset_ff;
    assign rx_dead = rx_dead_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_reset_bit_reads: assert property (@(posedge pclk) disable iff (!presetn)
        (state_ff == basic_mode_control_pkg::basic_mode_control_idle && wr_ctrl && pwdata[basic_mode_control_pkg::basic_mode_control_bit_reset])
        |=> ctrl_word[basic_mode_control_pkg::basic_mode_control_bit_reset] [*4])
        else $error("reset bit not held during soft reset");
    chk_strap_reload: assert property (@(posedge pclk) disable iff (!presetn)
        (state_ff == basic_mode_control_pkg::basic_mode_control_done) |=> (ctrl_ff.aneg_en == $past(strap.aneg)
        && ctrl_ff.speed_100 == $past(strap.speed) && ctrl_ff.full_duplex == $past(strap.duplex)))
        else $error("straps not reloaded");
    chk_loop_data: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_ff.loopback |=> mii_rxd == $past(mac_txd))
        else $error("loopback data not routed");
    chk_dead_time: assert property (@(posedge pclk) disable iff (!presetn)
        (dead_cnt_ff != 20'h00000 && ctrl_ff.loopback) |=> !mii_rx_dv)
        else $error("receive valid during dead time");
    chk_forced_speed: assert property (@(posedge pclk) disable iff (!presetn)
        !ctrl_ff.aneg_en |=> eff_speed_ff == $past(ctrl_ff.speed_100))
        else $error("forced speed not applied");
    chk_aneg_ignores: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_ff.aneg_en |=> $stable(eff_speed_ff) && $stable(eff_dup_ff))
        else $error("forced bits acted during auto-negotiation");
    chk_pin_power: assert property (@(posedge pclk) disable iff (!presetn)
        !power_down_interrupt_pin_n |-> ##2 ctrl_ff.power_down)
        else $error("power down pin did not set bit");
    chk_forced_dup: assert property (@(posedge pclk) disable iff (!presetn)
        !ctrl_ff.aneg_en |=> eff_dup_ff == $past(ctrl_ff.full_duplex))
        else $error("forced duplex not applied");
    chk_cor_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_stat && !error_pulse) |=> err_cnt_ff == '0)
        else $error("counter not cleared by read");
    chk_fixed_field: assert property (@(posedge pclk) disable iff (!presetn)
        stat_word[basic_mode_control_pkg::basic_mode_control_st_fixed_lsb +: 4] == basic_mode_control_pkg::basic_mode_control_fixed_val)
        else $error("fixed field changed");
endmodule // basic_mode_control_regs

// ### verification/basic_mode_control_apb_host.sv
// Purpose: Station management side model that issues APB transfers
// Assumes: Slave answers with pready; the bench timeout ends any hang
// Notes:   One transfer at a time; released address and data lines show inverted last values
`timescale 1ns/10ps
module basic_mode_control_apb_host (
    // Clock
    input wire logic pclk,
    // APB master
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
    end

    task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
                        output logic [31:0] rdata, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~addr;
        pwdata <= ~wdata;
    endtask
endmodule // basic_mode_control_apb_host

// ### verification/phy_basic_mode_control_register_test.sv
// Purpose: Self-checking bench for the basic mode control register block
// Assumes: Zero wait state slave; shortened dead time and soft reset counts
// Notes:   Random control writes from a fixed seed plus hand-made corners
`timescale 1ns/10ps
module phy_basic_mode_control_register_test;
    localparam int dead_cyc = 20;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, er, pd_pin_n;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, d;
    basic_mode_control_pkg::basic_mode_control_strap_t strap;
    basic_mode_control_pkg::basic_mode_control_ctrl_t ctrl;
    logic [3:0] mac_txd, line_rxd, mii_rxd;
    logic mac_tx_en, line_rx_dv, mii_rx_dv, link_ok, fault_event, busy_event, error_pulse;
    logic eff_speed_100, eff_full_duplex, core_reset, rx_dead, exp_spd, exp_dup;
    int err_total, num_checks, seed;

    always #50 pclk = ~pclk;

    basic_mode_control_apb_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    basic_mode_control_regs #(.dead_cycles(dead_cyc), .reset_cycles(8), .cnt_width(8)) uut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .strap(strap), .power_down_interrupt_pin_n(pd_pin_n),
        .mac_txd(mac_txd), .mac_tx_en(mac_tx_en), .line_rxd(line_rxd), .line_rx_dv(line_rx_dv),
        .mii_rxd(mii_rxd), .mii_rx_dv(mii_rx_dv), .link_ok(link_ok), .fault_event(fault_event),
        .busy_event(busy_event), .error_pulse(error_pulse), .ctrl(ctrl), .eff_speed_100(eff_speed_100),
        .eff_full_duplex(eff_full_duplex), .core_reset(core_reset), .rx_dead(rx_dead));

    function automatic logic [31:0] ctrl_word(input basic_mode_control_pkg::basic_mode_control_strap_t s);
        return {16'h0000, 2'b00, s.speed, s.aneg, 3'b000, s.duplex, 8'h00};
    endfunction

    function automatic logic [31:0] stat_word(input logic [7:0] cnt, input logic busy, input logic fault,
                                              input logic link);
        return {16'h0000, cnt, basic_mode_control_pkg::basic_mode_control_fixed_val, 1'b0, busy, fault, link};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        host.xfer(1'b1, a, v, rd, er);
    endtask

    task automatic rdw(input logic [11:0] a);
        host.xfer(1'b0, a, 32'h0000_0000, rd, er);
    endtask

    task automatic end_of_test;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        err_total++;
        end_of_test();
    end

    initial begin
        presetn = 1'b0;
        strap = 3'b110;
        pd_pin_n = 1'b1;
        mac_txd = 4'h0;
        mac_tx_en = 1'b0;
        line_rxd = 4'h9;
        line_rx_dv = 1'b1;
        link_ok = 1'b1;
        fault_event = 1'b0;
        busy_event = 1'b0;
        error_pulse = 1'b0;
        err_total = 0;
        num_checks = 0;
        seed = 15;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        rdw(basic_mode_control_pkg::basic_mode_control_addr_ctrl);
        check(rd, ctrl_word(strap), "ctrl after reset");
        check({27'h0, mii_rx_dv, mii_rxd}, {27'h0, 1'b1, 4'h9}, "normal rx path");
        rdw(12'h008);
        check({er, rd[30:0]}, 32'h8000_0000, "unmapped read");
        // ----------------------------------------
        // Random control writes, alternating auto-negotiation
        // ----------------------------------------
        for (int i = 0; i < 8; i++) begin
            d = $random(seed);
            d[15] = 1'b0;
            d[12] = i[0];
            wr(basic_mode_control_pkg::basic_mode_control_addr_ctrl, d);
            if (!d[12]) begin
                exp_spd = d[13];
                exp_dup = d[8];
            end
            rdw(basic_mode_control_pkg::basic_mode_control_addr_ctrl);
            check(rd, {16'h0000, d[15:0] & 16'h7d80}, "ctrl readback");
            check({30'h0, eff_speed_100, eff_full_duplex}, {30'h0, exp_spd, exp_dup}, "forced mode");
        end
        // ----------------------------------------
        // Power down pin sets the bit, software clears it
        // ----------------------------------------
        wr(basic_mode_control_pkg::basic_mode_control_addr_ctrl, 32'h0000_0000);
        pd_pin_n <= 1'b0;
        repeat (3) @(posedge pclk);
        pd_pin_n <= 1'b1;
        @(negedge pclk);
        check({31'h0, ctrl.power_down}, 32'h1, "pin power down");
        rdw(basic_mode_control_pkg::basic_mode_control_addr_ctrl);
        check(rd, 32'h0000_0800, "power down held");
        wr(basic_mode_control_pkg::basic_mode_control_addr_ctrl, 32'h0000_0000);
        rdw(basic_mode_control_pkg::basic_mode_control_addr_ctrl);
        check(rd, 32'h0000_0000, "power down cleared");
        // ----------------------------------------
        // Loopback with dead time
        // ----------------------------------------
        mac_txd <= 4'h6;
        mac_tx_en <= 1'b1;
        wr(basic_mode_control_pkg::basic_mode_control_addr_ctrl, 32'h0000_4000);
        repeat (2) @(negedge pclk);
        check({30'h0, rx_dead, mii_rx_dv}, 32'h2, "dead time");
        repeat (dead_cyc + 4) @(negedge pclk);
        check({26'h0, rx_dead, mii_rx_dv, mii_rxd}, {26'h0, 2'b01, 4'h6}, "looped data");
        wr(basic_mode_control_pkg::basic_mode_control_addr_ctrl, 32'h0000_0000);
        repeat (3) @(negedge pclk);
        check({27'h0, mii_rx_dv, mii_rxd}, {27'h0, 1'b1, 4'h9}, "loopback off");
        // ----------------------------------------
        // Status word kinds
        // ----------------------------------------
        rdw(basic_mode_control_pkg::basic_mode_control_addr_stat);
        link_ok <= 1'b0;
        fault_event <= 1'b1;
        busy_event <= 1'b1;
        error_pulse <= 1'b1;
        repeat (2) @(posedge pclk);
        link_ok <= 1'b1;
        fault_event <= 1'b0;
        repeat (3) @(posedge pclk);
        error_pulse <= 1'b0;
        repeat (2) @(posedge pclk);
        rdw(basic_mode_control_pkg::basic_mode_control_addr_stat);
        check(rd, stat_word(8'd5, 1'b1, 1'b1, 1'b0), "status held");
        busy_event <= 1'b0;
        wr(basic_mode_control_pkg::basic_mode_control_addr_stat, 32'hffff_ffff);
        rdw(basic_mode_control_pkg::basic_mode_control_addr_stat);
        check(rd, stat_word(8'd0, 1'b0, 1'b0, 1'b1), "status released");
        // ----------------------------------------
        // Software reset reloads straps
        // ----------------------------------------
        strap <= 3'b001;
        wr(basic_mode_control_pkg::basic_mode_control_addr_ctrl, 32'h0000_3580);
        wr(basic_mode_control_pkg::basic_mode_control_addr_ctrl, 32'h0000_8000);
        @(negedge pclk);
        check({31'h0, core_reset}, 32'h1, "core reset");
        rdw(basic_mode_control_pkg::basic_mode_control_addr_ctrl);
        check({31'h0, rd[15]}, 32'h1, "reset in progress");
        wr(basic_mode_control_pkg::basic_mode_control_addr_ctrl, 32'h0000_4000);
        for (int n = 0; n < 20 && rd[15] !== 1'b0; n++) rdw(basic_mode_control_pkg::basic_mode_control_addr_ctrl);
        check(rd, ctrl_word(strap), "restrapped");
        check({30'h0, eff_speed_100, eff_full_duplex}, 32'h1, "restrapped mode");
        end_of_test();
    end
endmodule // phy_basic_mode_control_register_test
